// *** asrb_assertions.sv ***
`timescale 1ns/10ps
module asrb_assertions (
	// clock and reset
	input wire logic MCLK_I,
	input wire logic RST_I,
	// bus
	input wire logic SCL_I,
	input wire logic SDA_O,
	input wire logic SDA_OE_O,
	// device side
	input wire asrb_pkg::asrb_cond_type COND_I,
	input wire logic EVENT_OUTPUT_PIN_N_O,
	input wire logic RESTART_O,
	input wire logic [15:0] SYSTEM_CONTROL_O
);
	import asrb_pkg::*;
	logic [3:0] low_cnt, next_low_cnt;
	logic seen, next_seen;
	// saturating count keeps the cause check bounded
	always_comb begin
		next_low_cnt = low_cnt + {3'h0, low_cnt != 4'h8};
		if (COND_I.watchdog_fired_state) begin
			next_low_cnt = 4'h0;
		end
		next_seen = seen | SDA_OE_O;
	end
	always_ff @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			low_cnt <= 4'h8;
			seen <= 1'b0;
		end else begin
			low_cnt <= next_low_cnt;
			seen <= next_seen;
		end
	end
	default clocking @(posedge MCLK_I); endclocking
	default disable iff (RST_I);
	sequence s_wd_rise;
		$rose(COND_I.watchdog_fired_state);
	endsequence
	sequence s_pulse;
		RESTART_O ##1 !RESTART_O;
	endsequence
	property p_sda_low;
		SDA_O == 1'b0;
	endproperty
	a_sda_low: assert property (p_sda_low)
		else $error("data pin driven high");
	property p_oe_scl_low;
		$changed(SDA_OE_O) |-> !SCL_I;
	endproperty
	a_oe_scl_low: assert property (p_oe_scl_low)
		else $error("data pin moved while clock high");
	property p_ctrl_ack;
		!$stable(SYSTEM_CONTROL_O) |-> SDA_OE_O;
	endproperty
	a_ctrl_ack: assert property (p_ctrl_ack)
		else $error("control changed outside a write");
	property p_restart_pulse;
		RESTART_O |=> !RESTART_O;
	endproperty
	a_restart_pulse: assert property (p_restart_pulse)
		else $error("restart longer than one cycle");
	property p_restart_after;
		s_wd_rise |-> ##[2:6] s_pulse;
	endproperty
	a_restart_after: assert property (p_restart_after)
		else $error("no restart after watchdog");
	property p_restart_cause;
		RESTART_O |-> low_cnt < 4'h7;
	endproperty
	a_restart_cause: assert property (p_restart_cause)
		else $error("restart without watchdog");
	property p_reset_state;
		$fell(RST_I) |-> EVENT_OUTPUT_PIN_N_O && !SDA_OE_O
			&& SYSTEM_CONTROL_O == 16'h6007;
	endproperty
	a_reset_state: assert property (p_reset_state)
		else $error("wrong state after reset");
	property p_quiet_pin;
		!seen |-> EVENT_OUTPUT_PIN_N_O;
	endproperty
	a_quiet_pin: assert property (p_quiet_pin)
		else $error("event pin low under reset mask");
endmodule

bind asrb_top asrb_assertions i_asrb_assertions (.MCLK_I(MCLK_I),
	.RST_I(RST_I), .SCL_I(SCL_I), .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O),
	.COND_I(COND_I), .EVENT_OUTPUT_PIN_N_O(EVENT_OUTPUT_PIN_N_O),
	.RESTART_O(RESTART_O), .SYSTEM_CONTROL_O(SYSTEM_CONTROL_O));

// *** asrb_host.sv ***
`timescale 1ns/10ps
module asrb_host (
	// clock
	input wire logic clk_i,
	// bus
	input wire logic dev_oe_i,
	output logic scl_o,
	output logic sda_o,
	// results
	output logic res_v_o,
	output logic [15:0] res_d_o
);
	int hp = 10;
	// released line floats to the pull-up
	wire logic line = sda_o & ~dev_oe_i;
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
		res_v_o = 1'b0;
		res_d_o = 16'h0000;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic bitx(input logic o, output logic i);
		sda_o <= o;
		tick(hp);
		scl_o <= 1'b1;
		tick(hp / 2);
		i = line;
		tick(hp - hp / 2);
		scl_o <= 1'b0;
		tick(1);
	endtask
	task automatic byte_x(input logic [7:0] o, input logic ao,
		output logic [7:0] i, output logic ai);
		for (int k = 7; k >= 0; k--) begin
			bitx(o[k], i[k]);
		end
		bitx(ao, ai);
	endtask
	task automatic post(input logic [15:0] d);
		res_d_o <= d;
		res_v_o <= 1'b1;
		tick(1);
		res_v_o <= 1'b0;
	endtask
	// a read passes w only for its length
	task automatic xfer(input logic [6:0] dev, input logic [7:0] a,
		input logic rd, input logic [15:0] w[$]);
		logic [7:0] hi;
		logic [7:0] lo;
		logic ak;
		sda_o <= 1'b1;
		tick(hp);
		scl_o <= 1'b1;
		tick(hp);
		sda_o <= 1'b0;
		tick(hp);
		scl_o <= 1'b0;
		tick(1);
		byte_x({dev, 1'b0}, 1'b1, hi, ak);
		post({15'h0000, ak});
		if (!ak) begin
			byte_x(a, 1'b1, hi, ak);
			if (rd) begin
				sda_o <= 1'b1;
				tick(hp);
				scl_o <= 1'b1;
				tick(hp);
				sda_o <= 1'b0;
				tick(hp);
				scl_o <= 1'b0;
				tick(1);
				byte_x({dev, 1'b1}, 1'b1, hi, ak);
			end
			foreach (w[k]) begin
				byte_x(rd ? 8'hFF : w[k][15:8], !rd, hi, ak);
				byte_x(rd ? 8'hFF : w[k][7:0],
					!(rd && k < w.size() - 1), lo, ak);
				if (rd) post({hi, lo});
			end
		end
		sda_o <= 1'b0;
		tick(hp);
		scl_o <= 1'b1;
		tick(hp);
		sda_o <= 1'b1;
		tick(hp);
	endtask
endmodule

// *** asrb_pkg.sv ***
package asrb_pkg;

	// ********************************
	// register map
	// ********************************
	localparam int ASRB_DW = 16;
	localparam logic [7:0] ADDR_ID = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h01;
	localparam logic [7:0] ADDR_FLAGS = 8'h02;
	localparam logic [7:0] ADDR_MASK = 8'h03;
	localparam logic [7:0] ADDR_BATTERY = 8'h6D;
	localparam logic [7:0] ADDR_TEMP = 8'h6E;
	localparam int NUM_RW = 16;
	// index 0 is system_control
	localparam logic [7:0] RW_OFFSET [NUM_RW] = '{
		8'h04, 8'h05, 8'h06, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C,
		8'h0D, 8'h0F, 8'h10, 8'h11, 8'h21, 8'h60, 8'h61, 8'h62};
	localparam logic [15:0] RW_RESET [NUM_RW] = '{
		16'h6007, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
		16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
		16'h0000, 16'h0000, 16'h0000, 16'h0000};
	localparam logic [15:0] SOFT_RESET_KEY = 16'h55AA;
	localparam logic [15:0] MASK_RESET = 16'hFFFF;
	localparam logic [15:0] FLAGS_RESET = 16'h4000;
	localparam logic [15:0] STATUS_USED = 16'h7FFF;
	localparam int BIT_WATCHDOG = 6;
	localparam int CTRL_SRC_BIT = 8;

	// ********************************
	// serial control bus
	// ********************************
	localparam logic [4:0] DEV_ADDR_HIGH = 5'h0D;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0000,
		ST_DEV = 4'b0001,
		ST_DEV_ACK = 4'b0010,
		ST_REG = 4'b0011,
		ST_REG_ACK = 4'b0100,
		ST_WR = 4'b0101,
		ST_WR_ACK = 4'b0110,
		ST_RD = 4'b0111,
		ST_RD_ACK = 4'b1000,
		ST_WAIT = 4'b1001
	} asrb_state_type;

	typedef struct packed {
		logic supply_below_low;
		logic supply_above_high;
		logic adaptive_boost_state;
		logic processor_ack_state;
		logic boost_overcurrent_state;
		logic boost_overvoltage_state;
		logic boost_startup_done;
		logic output_switching_state;
		logic output_clipping_state;
		logic watchdog_fired_state;
		logic ref_clock_missing_state;
		logic clocks_stable_state;
		logic amp_overcurrent_state;
		logic clipping_early_state;
		logic overtemperature_state;
		logic loop_locked_state;
	} asrb_cond_type;

endpackage

// *** asrb_top.sv ***
`timescale 1ns/10ps

module asrb_top #(
	parameter logic [15:0] PART_IDENTIFIER = 16'hA5C3 // arbitrary value
) (
	// clock and reset
	input wire logic MCLK_I,
	input wire logic RST_I,
	// serial control bus
	input wire logic SCL_I,
	input wire logic SDA_I,
	output logic SDA_O,
	output logic SDA_OE_O,
	input wire logic [1:0] ADDR_SEL_I,
	// analog conditions and monitors
	input wire asrb_pkg::asrb_cond_type COND_I,
	input wire logic [15:0] BATTERY_LEVEL_I,
	input wire logic [15:0] DIE_TEMP_I,
	// outputs to the rest of the device
	output logic EVENT_OUTPUT_PIN_N_O,
	output logic RESTART_O,
	output logic [15:0] SYSTEM_CONTROL_O
);
	import asrb_pkg::*;

	// ********************************
	// input synchronisers
	// ********************************
	logic scl_m, scl_s, scl_d;
	logic sda_m, sda_s, sda_d;
	logic [1:0] sel_m, sel_s;
	asrb_cond_type cond_m, cond_s;
	// monitor words change slowly; a torn sample only lasts a cycle
	logic [15:0] bat_m, bat_s, tmp_m, tmp_s;

	always_ff @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			scl_m <= 1'b1;
			scl_s <= 1'b1;
			scl_d <= 1'b1;
			sda_m <= 1'b1;
			sda_s <= 1'b1;
			sda_d <= 1'b1;
			sel_m <= 2'h0;
			sel_s <= 2'h0;
			cond_m <= '0;
			cond_s <= '0;
			bat_m <= 16'h0000;
			bat_s <= 16'h0000;
			tmp_m <= 16'h0000;
			tmp_s <= 16'h0000;
		end else begin
			scl_m <= SCL_I;
			scl_s <= scl_m;
			scl_d <= scl_s;
			sda_m <= SDA_I;
			sda_s <= sda_m;
			sda_d <= sda_s;
			sel_m <= ADDR_SEL_I;
			sel_s <= sel_m;
			cond_m <= COND_I;
			cond_s <= cond_m;
			bat_m <= BATTERY_LEVEL_I;
			bat_s <= bat_m;
			tmp_m <= DIE_TEMP_I;
			tmp_s <= tmp_m;
		end
	end

	logic scl_rise, scl_fall, start_det, stop_det;
	assign scl_rise = scl_s & ~scl_d;
	assign scl_fall = ~scl_s & scl_d;
	assign start_det = scl_s & scl_d & sda_d & ~sda_s;
	assign stop_det = scl_s & scl_d & ~sda_d & sda_s;

	// ********************************
	// status and event flags
	// ********************************
	logic uv, next_uv;
	logic [15:0] status, status_q, flags, next_flags;
	logic [15:0] mask;
	logic [15:0] ctrl;
	logic event_n, next_event_n, restart, next_restart;
	logic do_read_clear;

	always_comb begin
		next_uv = uv;
		if (cond_s.supply_below_low) begin
			next_uv = 1'b1;
		end else if (cond_s.supply_above_high) begin
			next_uv = 1'b0;
		end
	end

	always_comb begin
		status = {
			1'b0,
			uv,
			cond_s.adaptive_boost_state,
			cond_s.processor_ack_state,
			cond_s.boost_overcurrent_state,
			cond_s.boost_overvoltage_state,
			cond_s.boost_startup_done,
			cond_s.output_switching_state,
			cond_s.output_clipping_state,
			cond_s.watchdog_fired_state,
			cond_s.ref_clock_missing_state,
			cond_s.clocks_stable_state,
			cond_s.amp_overcurrent_state,
			cond_s.clipping_early_state,
			cond_s.overtemperature_state,
			cond_s.loop_locked_state
		};
	end

	always_comb begin
		next_flags = flags;
		if (do_read_clear) begin
			next_flags = 16'h0000;
		end
		// a change in the clearing cycle still lands
		next_flags = next_flags | ((status ^ status_q) & STATUS_USED);
		next_event_n = 1'b1;
		if (ctrl[CTRL_SRC_BIT]) begin
			next_event_n = ~|(status & ~mask);
		end else begin
			next_event_n = ~|(flags & ~mask);
		end
		next_restart = status[BIT_WATCHDOG] & ~status_q[BIT_WATCHDOG];
	end

	always_ff @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			uv <= 1'b0;
			status_q <= 16'h0000;
			flags <= FLAGS_RESET;
			event_n <= 1'b1;
			restart <= 1'b0;
		end else begin
			uv <= next_uv;
			status_q <= status;
			flags <= next_flags;
			event_n <= next_event_n;
			restart <= next_restart;
		end
	end

	assign EVENT_OUTPUT_PIN_N_O = event_n;
	assign RESTART_O = restart;

	// ********************************
	// serial control bus slave
	// ********************************
	asrb_state_type state, next_state;
	logic [3:0] bitcnt, next_bitcnt;
	logic [7:0] shift, next_shift;
	logic [7:0] reg_addr, next_reg_addr;
	logic [7:0] wr_hi, next_wr_hi;
	logic [7:0] rd_lo, next_rd_lo;
	logic hi_phase, next_hi_phase;
	logic sda_oe, next_sda_oe, sda_level;
	logic do_write;
	logic [7:0] rd_addr;
	logic [15:0] rd_word;
	logic [15:0] rw_q [NUM_RW];

	// next word address is read ahead while the master acknowledges
	assign rd_addr = (state == ST_RD_ACK) ? 8'(reg_addr + 8'h01) : reg_addr;

	always_comb begin
		rd_word = 16'h0000;
		case (rd_addr)
			ADDR_ID: rd_word = PART_IDENTIFIER;
			ADDR_STATUS: rd_word = status;
			ADDR_FLAGS: rd_word = flags;
			ADDR_MASK: rd_word = mask;
			ADDR_BATTERY: rd_word = bat_s;
			ADDR_TEMP: rd_word = tmp_s;
			default: begin
				for (int i = 0; i < NUM_RW; i++) begin
					if (rd_addr == RW_OFFSET[i]) begin
						rd_word = rw_q[i];
					end
				end
			end
		endcase
	end

	always_comb begin
		next_state = state;
		next_bitcnt = bitcnt;
		next_shift = shift;
		next_reg_addr = reg_addr;
		next_wr_hi = wr_hi;
		next_rd_lo = rd_lo;
		next_hi_phase = hi_phase;
		next_sda_oe = sda_oe;
		do_write = 1'b0;
		do_read_clear = 1'b0;
		if (start_det) begin
			next_state = ST_DEV;
			next_bitcnt = 4'h0;
			next_sda_oe = 1'b0;
		end else if (stop_det) begin
			next_state = ST_IDLE;
			next_sda_oe = 1'b0;
		end else begin
			case (state)
				ST_DEV, ST_REG, ST_WR: begin
					if (scl_rise) begin
						next_shift = {shift[6:0], sda_s};
						next_bitcnt = 4'(bitcnt + 4'h1);
					end else if (scl_fall && bitcnt == BITS_PER_BYTE) begin
						next_bitcnt = 4'h0;
						next_sda_oe = 1'b1;
						if (state == ST_DEV) begin
							next_state = ST_DEV_ACK;
							if (shift[7:1] != {DEV_ADDR_HIGH, sel_s}) begin
								next_state = ST_IDLE;
								next_sda_oe = 1'b0;
							end
						end else if (state == ST_REG) begin
							next_state = ST_REG_ACK;
							next_reg_addr = shift;
							next_hi_phase = 1'b1;
						end else begin
							next_state = ST_WR_ACK;
							if (hi_phase) begin
								next_wr_hi = shift;
								next_hi_phase = 1'b0;
							end else begin
								do_write = 1'b1;
								next_hi_phase = 1'b1;
								next_reg_addr = 8'(reg_addr + 8'h01);
							end
						end
					end
				end
				ST_DEV_ACK: begin
					if (scl_fall) begin
						if (shift[0]) begin
							next_state = ST_RD;
							next_shift = rd_word[15:8];
							next_rd_lo = rd_word[7:0];
							next_sda_oe = ~rd_word[15];
							next_bitcnt = 4'h1;
							next_hi_phase = 1'b0;
							do_read_clear = (rd_addr == ADDR_FLAGS);
						end else begin
							next_state = ST_REG;
							next_sda_oe = 1'b0;
						end
					end
				end
				ST_REG_ACK, ST_WR_ACK: begin
					if (scl_fall) begin
						next_state = ST_WR;
						next_sda_oe = 1'b0;
					end
				end
				ST_RD: begin
					if (scl_fall) begin
						if (bitcnt == BITS_PER_BYTE) begin
							next_state = ST_RD_ACK;
							next_sda_oe = 1'b0;
							next_bitcnt = 4'h0;
						end else begin
							next_shift = {shift[6:0], 1'b0};
							next_sda_oe = ~shift[6];
							next_bitcnt = 4'(bitcnt + 4'h1);
						end
					end
				end
				ST_RD_ACK: begin
					if (scl_rise && sda_s) begin
						next_state = ST_WAIT;
					end else if (scl_fall) begin
						next_state = ST_RD;
						next_bitcnt = 4'h1;
						if (hi_phase) begin
							next_reg_addr = rd_addr;
							next_shift = rd_word[15:8];
							next_rd_lo = rd_word[7:0];
							next_sda_oe = ~rd_word[15];
							next_hi_phase = 1'b0;
							do_read_clear = (rd_addr == ADDR_FLAGS);
						end else begin
							next_shift = rd_lo;
							next_sda_oe = ~rd_lo[7];
							next_hi_phase = 1'b1;
						end
					end
				end
				ST_WAIT: next_sda_oe = 1'b0;
				default: begin
					next_state = ST_IDLE;
					next_sda_oe = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			state <= ST_IDLE;
			bitcnt <= 4'h0;
			shift <= 8'h00;
			reg_addr <= 8'h00;
			wr_hi <= 8'h00;
			rd_lo <= 8'h00;
			hi_phase <= 1'b1;
			sda_oe <= 1'b0;
			sda_level <= 1'b0;
		end else begin
			state <= next_state;
			bitcnt <= next_bitcnt;
			shift <= next_shift;
			reg_addr <= next_reg_addr;
			wr_hi <= next_wr_hi;
			rd_lo <= next_rd_lo;
			hi_phase <= next_hi_phase;
			sda_oe <= next_sda_oe;
			sda_level <= 1'b0;
		end
	end

	assign SDA_O = sda_level;
	assign SDA_OE_O = sda_oe;

	// ********************************
	// configuration registers
	// ********************************
	logic [15:0] wr_data;
	logic soft_reset;
	logic [15:0] next_mask;

	assign wr_data = {wr_hi, shift};
	// identification stays read-only; only the key has an effect
	assign soft_reset = do_write && reg_addr == ADDR_ID
		&& wr_data == SOFT_RESET_KEY;

	always_comb begin
		next_mask = mask;
		if (soft_reset) begin
			next_mask = MASK_RESET;
		end else if (do_write && reg_addr == ADDR_MASK) begin
			next_mask = wr_data;
		end
	end

	always_ff @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			mask <= MASK_RESET;
		end else begin
			mask <= next_mask;
		end
	end

	for (genvar g = 0; g < NUM_RW; g++) begin : g_rw
		logic [15:0] next_rw;
		always_comb begin
			next_rw = rw_q[g];
			if (soft_reset) begin
				next_rw = RW_RESET[g];
			end else if (do_write && reg_addr == RW_OFFSET[g]) begin
				next_rw = wr_data;
			end
		end
		always_ff @(posedge MCLK_I or posedge RST_I) begin
			if (RST_I) begin
				rw_q[g] <= RW_RESET[g];
			end else begin
				rw_q[g] <= next_rw;
			end
		end
	end

	assign ctrl = rw_q[0];
	assign SYSTEM_CONTROL_O = rw_q[0];

endmodule

// *** tb_amp_status_register_bank.sv ***
`timescale 1ns/10ps
module tb_amp_status_register_bank;
	import asrb_pkg::*;
	localparam logic [15:0] PART_ID = 16'h3C96; // arbitrary value
	localparam logic [6:0] DEV = {DEV_ADDR_HIGH, 2'b10};
	logic mclk = 1'b0;
	logic rst = 1'b1;
	asrb_cond_type cond = 16'h0000;
	logic [15:0] batt = 16'h0000;
	logic [15:0] temp = 16'h0000;
	logic scl, sda_m, sda_oe, sda_d, evt_n, restart, res_v, uv;
	logic [15:0] ctrl, res_d;
	logic [31:0] seed = 32'h591F2B74;
	logic [31:0] r;
	logic [15:0] exp_q[$];
	int err_total = 0;
	int total_checks = 0;
	int cycles = 0;
	wire logic sda_line = sda_m & ~sda_oe;
	always #25 mclk = ~mclk;
	asrb_top #(.PART_IDENTIFIER(PART_ID)) i_asrb_top (.MCLK_I(mclk),
		.RST_I(rst), .SCL_I(scl), .SDA_I(sda_line), .SDA_O(sda_d),
		.SDA_OE_O(sda_oe), .ADDR_SEL_I(2'b10), .COND_I(cond),
		.BATTERY_LEVEL_I(batt), .DIE_TEMP_I(temp),
		.EVENT_OUTPUT_PIN_N_O(evt_n), .RESTART_O(restart),
		.SYSTEM_CONTROL_O(ctrl));
	asrb_host i_asrb_host (.clk_i(mclk), .dev_oe_i(sda_oe), .scl_o(scl),
		.sda_o(sda_m), .res_v_o(res_v), .res_d_o(res_d));
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic chk(input string n, input logic [15:0] e,
		input logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic close_out();
		if (err_total == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] w[$]);
		exp_q.push_back(16'h0000);
		i_asrb_host.xfer(DEV, a, 1'b0, w);
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e[$]);
		exp_q.push_back(16'h0000);
		foreach (e[k]) exp_q.push_back(e[k]);
		i_asrb_host.xfer(DEV, a, 1'b1, e);
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(posedge mclk);
	endtask
	// ********
	// result monitor and hang guard
	// ********
	always @(posedge mclk) begin
		cycles++;
		if (res_v) begin
			chk("bus word", exp_q.size() ? exp_q.pop_front() : 16'hXXXX, res_d);
		end
		if (cycles == 90000) begin
			err_total++;
			close_out();
		end
	end
	initial begin
		uv = 1'b0;
		wait_n(8);
		rst <= 1'b0;
		wait_n(4);
		rd(8'h00, '{PART_ID, 16'h0000, FLAGS_RESET, MASK_RESET, 16'h6007});
		exp_q.push_back(16'h0001);
		i_asrb_host.xfer({DEV_ADDR_HIGH, 2'b01}, 8'h00, 1'b0, '{});
		cond.loop_locked_state <= 1'b1;
		wait_n(10);
		rd(8'h01, '{16'h0001, 16'h0001});
		wr(8'h03, '{16'hFFFE});
		cond.loop_locked_state <= 1'b0;
		wait_n(10);
		chk("event pin", 16'h0000, {15'h0000, evt_n});
		rd(8'h02, '{16'h0001});
		wait_n(4);
		chk("event pin", 16'h0001, {15'h0000, evt_n});
		// status as pin source: pin follows the unmasked level itself
		wr(8'h04, '{16'h0123, 16'h4567});
		chk("control out", 16'h0123, ctrl);
		cond.loop_locked_state <= 1'b1;
		wait_n(10);
		chk("event pin", 16'h0000, {15'h0000, evt_n});
		cond.loop_locked_state <= 1'b0;
		wait_n(10);
		chk("event pin", 16'h0001, {15'h0000, evt_n});
		wr(8'h01, '{16'hFFFF});
		wr(8'h00, '{16'h1234});
		rd(8'h00, '{PART_ID, 16'h0000, 16'h0001, 16'hFFFE, 16'h0123, 16'h4567});
		wr(8'h00, '{SOFT_RESET_KEY});
		chk("control out", 16'h6007, ctrl);
		rd(8'h03, '{MASK_RESET, 16'h6007, 16'h0000});
		// slow host stretches every clock phase
		i_asrb_host.hp = 30;
		rd(8'h7F, '{16'h0000});
		i_asrb_host.hp = 10;
		repeat (8) begin
			r = rnd();
			cond <= asrb_cond_type'(r[15:0]);
			batt <= r[31:16];
			temp <= r[15:0] ^ r[31:16];
			uv = r[15] | (uv & ~r[14]);
			wait_n(20);
			rd(8'h01, '{{1'b0, uv, r[13:0]}});
			rd(8'h6D, '{r[31:16], r[15:0] ^ r[31:16]});
		end
		close_out();
	end
endmodule
